/* rtl/cism_top.v */
// Codec interrupt status, mask and mode logic behind an AXI4-Lite slave.
`include "cism_map.vh"
`timescale 1ns/1ps
`default_nettype none

module cism_top (
	input  wire        REF_CLK,
	input  wire        RST_B,
	input  wire [7:0]  S_AXI_AWADDR,
	input  wire [2:0]  S_AXI_AWPROT,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [7:0]  S_AXI_ARADDR,
	input  wire [2:0]  S_AXI_ARPROT,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	input  wire        CONV2_LEFT_SILENCE,
	input  wire        CONV2_RIGHT_SILENCE,
	input  wire        CONV1_LEFT_SILENCE,
	input  wire        CONV1_RIGHT_SILENCE,
	input  wire        PORT2_CLKFAULT,
	input  wire        PORT1_CLKFAULT,
	input  wire        POS_CLIP,
	input  wire        NEG_CLIP,
	output reg         IRQ_PIN_B,
	output reg         LIVE_OVERRANGE_PIN
);

	reg  [7:0]  irq_mode;
	reg  [7:0]  irq_mask;
	reg  [7:0]  event_flags;
	reg  [7:0]  src_prev;
	reg  [7:0]  irq_pending;
	reg         aw_held;
	reg         w_held;
	reg  [7:0]  aw_addr;
	reg  [7:0]  w_data;
	reg         w_lane0;
	wire [7:0]  src_now;
	wire [7:0]  onset;
	wire [7:0]  removal;
	wire [7:0]  level_act;
	wire        do_write;
	wire        rd_take;
	wire        flags_read;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_rresp;

	// Event sources are levels from logic on this clock, so no synchroniser.
	assign src_now = {CONV2_LEFT_SILENCE, CONV2_RIGHT_SILENCE,
		CONV1_LEFT_SILENCE, CONV1_RIGHT_SILENCE,
		PORT2_CLKFAULT, PORT1_CLKFAULT,
		POS_CLIP, NEG_CLIP};
	assign onset   = src_now & ~src_prev;
	assign removal = ~src_now & src_prev;

	// Write address and data may arrive in either order.
	assign S_AXI_AWREADY = ~aw_held;
	assign S_AXI_WREADY  = ~w_held;
	assign do_write      = aw_held & w_held & ~S_AXI_BVALID;

	// One read in flight; the answer register must drain first.
	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	assign rd_take       = S_AXI_ARVALID & ~S_AXI_RVALID;
	assign flags_read    = rd_take &
		(S_AXI_ARADDR == `CISM_ADDR_FLAGS);

	// Selects the group mode field that governs a given flag bit.
	function [1:0] mode_of;
		input integer idx;
		input [7:0]   mode;
		begin
			if (idx >= `CISM_BIT_C1_RIGHT)
				mode_of = mode[`CISM_FLD_SILENCE_MODE];
			else if (idx == `CISM_BIT_P2_FAULT)
				mode_of = mode[`CISM_FLD_P2_MODE];
			else if (idx == `CISM_BIT_P1_FAULT)
				mode_of = mode[`CISM_FLD_P1_MODE];
			else
				mode_of = mode[`CISM_FLD_CLIP_MODE];
		end
	endfunction

	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			src_prev <= 8'h00;
		end else begin
			src_prev <= src_now;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_src
			wire [1:0] m;
			wire       edge_hit;
			assign m = mode_of(gi, irq_mode);
			// Reserved mode 11 neither latches nor holds the pin.
			assign edge_hit = ((m == `CISM_MODE_ARRIVAL) & onset[gi]) |
				((m == `CISM_MODE_REMOVAL) & removal[gi]);
			assign level_act[gi] = (m == `CISM_MODE_LEVEL) &
				src_now[gi];

			// A new onset in the read cycle wins over the clear.
			always @(posedge REF_CLK or negedge RST_B) begin
				if (!RST_B) begin
					event_flags[gi] <= 1'b0;
				end else if (onset[gi]) begin
					event_flags[gi] <= 1'b1;
				end else if (flags_read) begin
					event_flags[gi] <= 1'b0;
				end
			end

			// Masked sources never latch a pending bit; unmasking later stays quiet unless a level-mode source is still high.
			always @(posedge REF_CLK or negedge RST_B) begin
				if (!RST_B) begin
					irq_pending[gi] <= 1'b0;
				end else if (edge_hit & ~irq_mask[gi]) begin
					irq_pending[gi] <= 1'b1;
				end else if (flags_read) begin
					irq_pending[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Flag sources per bit: via src_now.
	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			IRQ_PIN_B          <= 1'b1;
			LIVE_OVERRANGE_PIN <= 1'b0;
		end else begin
			IRQ_PIN_B <= ~(|((irq_pending | level_act) &
				~irq_mask));
			LIVE_OVERRANGE_PIN <= POS_CLIP | NEG_CLIP;
		end
	end

	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 8'h00;
			w_lane0      <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `CISM_RESP_OKAY;
			irq_mode     <= `CISM_RST_MODE;
			irq_mask     <= `CISM_RST_MASK;
		end else begin
			if (S_AXI_AWVALID & ~aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID & ~w_held) begin
				w_held  <= 1'b1;
				w_data  <= S_AXI_WDATA[7:0];
				w_lane0 <= S_AXI_WSTRB[0];
			end
			if (S_AXI_BVALID & S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= `CISM_RESP_OKAY;
				// Only lane 0 carries register bits; upper lanes are void.
				if (aw_addr == `CISM_ADDR_MODE) begin
					if (w_lane0) begin
						irq_mode <= w_data;
					end
				end else if (aw_addr == `CISM_ADDR_MASK) begin
					if (w_lane0) begin
						irq_mask <= w_data;
					end
				end else if (aw_addr == `CISM_ADDR_FLAGS) begin
					S_AXI_BRESP <= `CISM_RESP_OKAY;
				end else begin
					S_AXI_BRESP <= `CISM_RESP_SLVERR;
				end
			end
		end
	end

	always @* begin
		next_rdata = 32'h0000_0000;
		next_rresp = `CISM_RESP_OKAY;
		case (S_AXI_ARADDR)
			`CISM_ADDR_MODE: begin
				next_rdata = {24'h00_0000, irq_mode};
			end
			`CISM_ADDR_MASK: begin
				next_rdata = {24'h00_0000, irq_mask};
			end
			`CISM_ADDR_FLAGS: begin
				next_rdata = {24'h00_0000, event_flags};
			end
			default: begin
				next_rresp = `CISM_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= `CISM_RESP_OKAY;
		end else if (rd_take) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= next_rdata;
			S_AXI_RRESP  <= next_rresp;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule // cism_top

`default_nettype wire

/* rtl/cism_map.vh */
// Register map, field positions and reset values of the interrupt block.
`ifndef CISM_MAP_VH
`define CISM_MAP_VH

`define CISM_IDX_MODE       6'h16
`define CISM_IDX_MASK       6'h17
`define CISM_IDX_FLAGS      6'h18
`define CISM_ADDR_MODE      {`CISM_IDX_MODE, 2'b00}
`define CISM_ADDR_MASK      {`CISM_IDX_MASK, 2'b00}
`define CISM_ADDR_FLAGS     {`CISM_IDX_FLAGS, 2'b00}

`define CISM_RST_MODE       8'h00
`define CISM_RST_MASK       8'hFF
`define CISM_RST_FLAGS      8'h00

`define CISM_BIT_C2_LEFT    7
`define CISM_BIT_C2_RIGHT   6
`define CISM_BIT_C1_LEFT    5
`define CISM_BIT_C1_RIGHT   4
`define CISM_BIT_P2_FAULT   3
`define CISM_BIT_P1_FAULT   2
`define CISM_BIT_POS_CLIP   1
`define CISM_BIT_NEG_CLIP   0

`define CISM_FLD_CLIP_MODE      1:0
`define CISM_FLD_SILENCE_MODE   3:2
`define CISM_FLD_P1_MODE        5:4
`define CISM_FLD_P2_MODE        7:6

`define CISM_MODE_ARRIVAL   2'h0
`define CISM_MODE_REMOVAL   2'h1
`define CISM_MODE_LEVEL     2'h2

`define CISM_RESP_OKAY      2'h0
`define CISM_RESP_SLVERR    2'h2

`endif

/* tb/cism_assertions.sv */
// Port-level checks of the interrupt block, bound into its top.
`timescale 1ns/1ps
`default_nettype none
module cism_chk (
	input wire       REF_CLK, RST_B, POS_CLIP, NEG_CLIP, LIVE_OVERRANGE_PIN,
	input wire       S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
	input wire       S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
	input wire       S_AXI_RVALID, S_AXI_RREADY,
	input wire [7:0] S_AXI_ARADDR,
	input wire [31:0] S_AXI_RDATA,
	input wire [1:0] S_AXI_RRESP
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	wire ar_go = S_AXI_ARVALID && S_AXI_ARREADY;
	chk_live_pin: assert property (LIVE_OVERRANGE_PIN == $past(POS_CLIP | NEG_CLIP))
		else $error("overrange pin does not follow clip inputs");
	chk_read_next: assert property (ar_go |=> S_AXI_RVALID)
		else $error("read answer late");
	chk_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read answer dropped");
	chk_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("address taken during answer");
	chk_write_resp: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
		else $error("write answer late");
	chk_resp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write answer dropped");
	chk_unmapped_read: assert property (ar_go && !(S_AXI_ARADDR inside {8'h58, 8'h5C, 8'h60}) |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
		else $error("unmapped read not refused");
	chk_flag_width: assert property (ar_go && S_AXI_ARADDR == 8'h60 |=> S_AXI_RDATA[31:8] == 24'h0)
		else $error("flag read has upper bits");
endmodule // cism_chk
bind cism_top cism_chk chk (.*);
`default_nettype wire

/* tb/cism_host.sv */
// Host model: an AXI4-Lite master with bounded waits.
`timescale 1ns/1ps
`default_nettype none
module cism_host (
	input wire        REF_CLK, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID,
	input wire        S_AXI_ARREADY, S_AXI_RVALID,
	input wire [1:0]  S_AXI_BRESP, S_AXI_RRESP,
	input wire [31:0] S_AXI_RDATA,
	output logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00,
	output logic [31:0] S_AXI_WDATA = 32'h0,
	output logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0,
	output logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0
);
	// Tasks open with an edge so no signal is assigned twice in one step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit pa = 1;
		bit pw = 1;
		int n = 0;
		@(posedge REF_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		S_AXI_BREADY <= 1;
		forever begin
			@(posedge REF_CLK);
			if (n++ == 40) begin
				cism_top_test.fail_count++;
				cism_top_test.final_report();
			end
			if (!pa && !pw && S_AXI_BVALID) break;
			if (S_AXI_AWREADY) begin
				pa = 0;
				S_AXI_AWVALID <= 0;
			end
			if (S_AXI_WREADY) begin
				pw = 0;
				S_AXI_WVALID <= 0;
			end
		end
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit pa = 1;
		int n = 0;
		@(posedge REF_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1;
		S_AXI_RREADY <= 1;
		forever begin
			@(posedge REF_CLK);
			if (n++ == 40) begin
				cism_top_test.fail_count++;
				cism_top_test.final_report();
			end
			if (!pa && S_AXI_RVALID) break;
			if (S_AXI_ARREADY) begin
				pa = 0;
				S_AXI_ARVALID <= 0;
			end
		end
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 0;
	endtask
endmodule // cism_host
`default_nettype wire

/* tb/cism_top_test.sv */
// Self-checking bench of the codec interrupt block.
`timescale 1ns/1ps
`default_nettype none
module cism_top_test;
	logic REF_CLK = 0, RST_B = 0;
	logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, ev = 8'h00, p;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, S_AXI_RREADY, IRQ_PIN_B, LIVE_OVERRANGE_PIN;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire CONV2_LEFT_SILENCE, CONV2_RIGHT_SILENCE, CONV1_LEFT_SILENCE;
	wire CONV1_RIGHT_SILENCE, PORT2_CLKFAULT, PORT1_CLKFAULT, POS_CLIP, NEG_CLIP;
	int fail_count = 0, n_compared = 0, b, m, mk;
	assign {CONV2_LEFT_SILENCE, CONV2_RIGHT_SILENCE, CONV1_LEFT_SILENCE,
		CONV1_RIGHT_SILENCE, PORT2_CLKFAULT, PORT1_CLKFAULT, POS_CLIP,
		NEG_CLIP} = ev;
	always #2.5 REF_CLK = ~REF_CLK;
	cism_host host (.*);
	cism_top dut (.*);
	task chk(input logic [31:0] seen, exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Pin level after a rise (ph 0) or a fall (ph 1) of an unmasked source.
	function logic exp_pin(int m, int ph);
		return ph ? m > 1 : !(m == 0 || m == 2);
	endfunction
	task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		chk(d, e, "read data");
		chk(r, er, "read resp");
	endtask
	task wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		host.wr(a, d, r);
		chk(r, er, "write resp");
	endtask
	initial begin
		void'($urandom(1));
		repeat (3) @(posedge REF_CLK);
		RST_B <= 1;
		rc(8'h58, 32'h0, 2'h0);
		rc(8'h5C, 32'hFF, 2'h0);
		rc(8'h60, 32'h0, 2'h0);
		rc(8'h00, 32'h0, 2'h2);
		wc(8'h04, 32'h1, 2'h2);
		wc(8'h60, 32'hFF, 2'h0);
		rc(8'h60, 32'h0, 2'h0);
		$display("test registers done");
		// Flags must set on a one-cycle pulse and survive a random wait.
		for (int i = 0; i < 6; i++) begin
			p = i ? 8'($urandom) : 8'hFF;
			ev <= p;
			@(posedge REF_CLK);
			ev <= 8'h00;
			repeat (2 + $urandom % 20) @(posedge REF_CLK);
			rc(8'h60, p, 2'h0);
			rc(8'h60, 32'h0, 2'h0);
		end
		$display("test flags done");
		for (int k = 0; k < 64; k++) begin
			b = k % 8;
			m = (k / 8) % 4;
			mk = k / 32;
			wc(8'h5C, mk ? 32'hFF : 32'(~(8'h01 << b)), 2'h0);
			wc(8'h58, 32'(m * 8'h55), 2'h0);
			ev[b] <= 1;
			repeat (4) @(posedge REF_CLK);
			chk(IRQ_PIN_B, mk | exp_pin(m, 0), "pin after rise");
			chk(LIVE_OVERRANGE_PIN, b < 2, "overrange pin");
			ev[b] <= 0;
			repeat (4) @(posedge REF_CLK);
			chk(IRQ_PIN_B, mk | exp_pin(m, 1), "pin after fall");
			rc(8'h60, 32'h1 << b, 2'h0);
			repeat (3) @(posedge REF_CLK);
			chk(IRQ_PIN_B, 1'b1, "pin after read");
		end
		$display("test interrupts done");
		// An onset on the very edge that takes a flag read must survive it.
		fork
			rc(8'h60, 32'h0, 2'h0);
			begin
				@(posedge REF_CLK);
				ev <= 8'h01;
				@(posedge REF_CLK);
				ev <= 8'h00;
			end
		join
		rc(8'h60, 32'h1, 2'h0);
		$display("test collision done");
		final_report();
	end
endmodule // cism_top_test
`default_nettype wire
